// ### cwd_map.svh
`ifndef CWD_MAP_SVH
`define CWD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CWD_AW          8
`define CWD_OFF_CWL     8'h00
`define CWD_OFF_CWH     8'h04
`define CWD_OFF_HCFG    8'h08
`define CWD_OFF_STAT    8'h0c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CWD_CWL_RST     16'h0000
`define CWD_CWH_RST     1'b0
`define CWD_HCFG_RST    2'h0
`define CWD_RD_ZERO     32'h0000_0000

// ----------------------------------------
// Low command word bit positions
// ----------------------------------------
`define CWD_B_STOP      0
`define CWD_B_START     1
`define CWD_B_REV       2
`define CWD_B_LOCAL     3
`define CWD_B_FRST      4
`define CWD_B_EXTB      5
`define CWD_B_RUNDIS    6
`define CWD_B_HRAMP     7
`define CWD_B_HEMER     8
`define CWD_B_HCOAST    9
`define CWD_B_RAMP2     10
`define CWD_B_ROUT0     11
`define CWD_B_RHOLD     12
`define CWD_B_RIN0      13
`define CWD_B_LOCK      14
`define CWD_B_TLIM2     15

// High word: bit 16 of the full word sits at index 0
`define CWD_B_BUSLOC    0

`endif

// ### cwd_pkg.sv
package cwd_pkg;

    typedef enum logic [1:0] {
        cwd_hm_ramp  = 2'b00,
        cwd_hm_coast = 2'b01,
        cwd_hm_emer  = 2'b10
    } cwd_halt_t;

    typedef enum logic [1:0] {
        cwd_st_idle = 2'b00,
        cwd_st_run  = 2'b01,
        cwd_st_halt = 2'b10
    } cwd_state_t;

endpackage

// ### cwd_halt_if.sv
`timescale 1ns/1ns
interface cwd_halt_if;
    import cwd_pkg::*;
    logic      stop;
    logic      start;
    logic      req_ramp;
    logic      req_emer;
    logic      req_coast;
    cwd_halt_t cfg_mode;
    logic      halt;
    logic      run;
    cwd_halt_t mode;

    modport src (output stop, start, req_ramp, req_emer, req_coast, cfg_mode,
                 input  halt, run, mode);
    modport sel (input  stop, start, req_ramp, req_emer, req_coast, cfg_mode,
                 output halt, run, mode);
endinterface

// ### cwd_halt_sel.sv
`timescale 1ns/1ns
module cwd_halt_sel
    import cwd_pkg::*;
(
    // Request and resolved command
    cwd_halt_if.sel hs
);

    // ----------------------------------------
    // Stop and start priority
    // ----------------------------------------
    // Stop beats start when both are set
    assign hs.halt = hs.stop; // R02
    assign hs.run  = hs.start & ~hs.stop; // R03

    // ----------------------------------------
    // Stop mode resolution
    // ----------------------------------------
    // Mode requests count only beside the stop bit.
    // Harshest request wins if several are set.
    wire use_emer  = hs.stop & hs.req_emer; // R07
    wire use_coast = hs.stop & hs.req_coast; // R08
    wire use_ramp  = hs.stop & hs.req_ramp; // R06

    assign hs.mode = use_emer  ? cwd_hm_emer  :
                     use_coast ? cwd_hm_coast :
                     use_ramp  ? cwd_hm_ramp  :
                     hs.cfg_mode; // R02

endmodule

// ### cwd_decoder.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "cwd_map.svh"
// How it works
// R01: Command word is 32 bits; low and high 16-bit halves are separate registers.
// R02: Stop bit halts using configured stop mode unless a mode request bit is set.
// R03: Start bit runs the drive; stop together with start means stop.
// R04: Direction is bit 2 XOR reference sign; 1 is reverse.
// R05: Bit 5 picks external location b when 1, location a when 0.
// R06: Bit 7 with stop halts along the selected deceleration ramp.
// R07: Bit 8 with stop performs an emergency halt.
// R08: Bit 9 with stop coasts to a halt.
// R09: Bit 10 picks ramp pair 2 when 1, pair 1 when 0.
// R10: Bit 11 forces ramp output to zero while set.
// R11: Bit 12 holds the ramp output at its present value while set.
// R12: Bit 13 forces ramp input to zero while set.
// R13: Bit 14 blocks the panel key from entering local mode.
// R14: Bit 15 picks torque limit set 2 when 1, set 1 when 0.
// R15: Upper bit 16 requests bus local command mode.
// R16: Bit 3 enters local mode when 1, external mode when 0.
// R17: Fault reset fires only on a 0-to-1 change of bit 4.
// R18: Bit 6 activates run disable when 1, run enable when 0.
module cwd_decoder
    import cwd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,

    // Register port
    input  wire logic [`CWD_AW-1:0] addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [31:0]        rdata_o,

    // Drive side inputs
    input  wire logic              ref_sign_i,
    input  wire logic              panel_location_key_i,
    input  wire logic              halt_done_i,

    // Start and stop commands
    output logic                   run_cmd_o,
    output logic                   halt_cmd_o,
    output cwd_halt_t              halt_mode_o,
    output cwd_state_t             cmd_state_o,
    output logic                   reverse_o,

    // Control location
    output logic                   local_mode_o,
    output logic                   external_location_b_o,
    output logic                   panel_local_lockout_o,
    output logic                   bus_local_command_mode_o,

    // Run and fault control
    output logic                   run_disable_o,
    output logic                   fault_reset_o,

    // Ramp generator
    output logic                   ramp_pair2_o,
    output logic                   ramp_out_zero_o,
    output logic                   ramp_hold_o,
    output logic                   ramp_in_zero_o,

    // Torque limits
    output logic                   second_torque_limit_select_o
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Exact match only, so an unmapped offset
    // can never alias onto the command word.
    function automatic logic hit(
        input logic [`CWD_AW-1:0] a,
        input logic [`CWD_AW-1:0] off
    );
        hit = (a == off);
    endfunction

    wire wr_cwl  = wr_i & hit(addr_i, `CWD_OFF_CWL);
    wire wr_cwh  = wr_i & hit(addr_i, `CWD_OFF_CWH);
    wire wr_hcfg = wr_i & hit(addr_i, `CWD_OFF_HCFG);

    wire rd_cwl  = hit(addr_i, `CWD_OFF_CWL);
    wire rd_cwh  = hit(addr_i, `CWD_OFF_CWH);
    wire rd_hcfg = hit(addr_i, `CWD_OFF_HCFG);
    wire rd_stat = hit(addr_i, `CWD_OFF_STAT);

    // ----------------------------------------
    // Command word registers
    // ----------------------------------------
    logic [15:0] cwl_ff;
    logic        cwh_busloc_ff;
    cwd_halt_t   hcfg_ff;

    // Low and high halves written apart
    wire [15:0] nxt_cwl = wr_cwl ? wdata_i[15:0] : cwl_ff; // R01
    wire nxt_cwh_busloc = wr_cwh ? wdata_i[16 + `CWD_B_BUSLOC] : cwh_busloc_ff; // R01

    // Unused stop mode code falls back to ramp
    wire [1:0]  hcfg_raw = wdata_i[1:0];
    wire        hcfg_ok  = (hcfg_raw == cwd_hm_coast) | (hcfg_raw == cwd_hm_emer);
    cwd_halt_t  hcfg_val;
    assign hcfg_val = hcfg_ok ? cwd_halt_t'(hcfg_raw) : cwd_hm_ramp;
    cwd_halt_t  nxt_hcfg;
    assign nxt_hcfg = wr_hcfg ? hcfg_val : hcfg_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cwl_ff <= `CWD_CWL_RST;
        end else begin
            cwl_ff <= nxt_cwl;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cwh_busloc_ff <= `CWD_CWH_RST;
        end else begin
            cwh_busloc_ff <= nxt_cwh_busloc;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hcfg_ff <= cwd_halt_t'(`CWD_HCFG_RST);
        end else begin
            hcfg_ff <= nxt_hcfg;
        end
    end

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    wire f_stop   = cwl_ff[`CWD_B_STOP];
    wire f_start  = cwl_ff[`CWD_B_START];
    wire f_rev    = cwl_ff[`CWD_B_REV];
    wire f_local  = cwl_ff[`CWD_B_LOCAL];
    wire f_extb   = cwl_ff[`CWD_B_EXTB];
    wire f_rundis = cwl_ff[`CWD_B_RUNDIS];
    wire f_hramp  = cwl_ff[`CWD_B_HRAMP];
    wire f_hemer  = cwl_ff[`CWD_B_HEMER];
    wire f_hcoast = cwl_ff[`CWD_B_HCOAST];
    wire f_ramp2  = cwl_ff[`CWD_B_RAMP2];
    wire f_rout0  = cwl_ff[`CWD_B_ROUT0];
    wire f_rhold  = cwl_ff[`CWD_B_RHOLD];
    wire f_rin0   = cwl_ff[`CWD_B_RIN0];
    wire f_lock   = cwl_ff[`CWD_B_LOCK];
    wire f_tlim2  = cwl_ff[`CWD_B_TLIM2];

    // ----------------------------------------
    // Stop mode and priority
    // ----------------------------------------
    cwd_halt_if hs ();

    assign hs.stop      = f_stop;
    assign hs.start     = f_start;
    assign hs.req_ramp  = f_hramp;
    assign hs.req_emer  = f_hemer;
    assign hs.req_coast = f_hcoast;
    assign hs.cfg_mode  = hcfg_ff;

    cwd_halt_sel u_halt_sel (
        .hs (hs.sel)
    );

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    // The halt state holds until the drive
    // reports standstill, but halt_cmd_o follows
    // the stop bit and can drop before that.
    cwd_state_t state_ff;
    cwd_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cwd_st_idle: begin
                if (hs.run) begin
                    nxt_state = cwd_st_run; // R03
                end
            end
            cwd_st_run: begin
                if (hs.halt) begin
                    nxt_state = cwd_st_halt; // R02
                end
            end
            cwd_st_halt: begin
                if (halt_done_i) begin
                    nxt_state = hs.run ? cwd_st_run : cwd_st_idle;
                end
            end
            default: begin
                nxt_state = cwd_st_idle;
            end
        endcase
    end

    // Mode is frozen once a halt begins
    cwd_halt_t mode_ff;
    cwd_halt_t nxt_mode;
    assign nxt_mode = (state_ff != cwd_st_halt) ? hs.mode : mode_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= cwd_st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= cwd_hm_ramp;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ----------------------------------------
    // Fault reset edge
    // ----------------------------------------
    // Edge taken against the stored bit so a
    // rewrite of the same 1 gives no pulse.
    wire nxt_frst = wr_cwl & wdata_i[`CWD_B_FRST] & ~cwl_ff[`CWD_B_FRST]; // R17

    // ----------------------------------------
    // Control location
    // ----------------------------------------
    // Panel key toggles location; entering local
    // is refused while the lockout bit is set.
    logic local_ff;
    wire  key_to_local  = panel_location_key_i & ~local_ff & ~f_lock; // R13
    wire  key_to_remote = panel_location_key_i & local_ff;
    wire  wr_location   = wr_cwl;
    wire  nxt_local     = wr_location   ? wdata_i[`CWD_B_LOCAL] : // R16
                          key_to_local  ? 1'b1 :
                          key_to_remote ? 1'b0 :
                          local_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            local_ff <= 1'b0;
        end else begin
            local_ff <= nxt_local;
        end
    end

    // ----------------------------------------
    // Command outputs
    // ----------------------------------------
    // Every command leaves on a clock edge, so the
    // drive never sees a glitch from the bus decode.
    wire nxt_reverse = f_rev ^ ref_sign_i; // R04

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_cmd_o     <= 1'b0;
            halt_cmd_o    <= 1'b0;
            reverse_o     <= 1'b0;
            fault_reset_o <= 1'b0;
        end else begin
            run_cmd_o     <= hs.run; // R03
            halt_cmd_o    <= hs.halt; // R02
            reverse_o     <= nxt_reverse; // R04
            fault_reset_o <= nxt_frst; // R17
        end
    end

    // ----------------------------------------
    // Location and run control outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            external_location_b_o    <= 1'b0;
            panel_local_lockout_o    <= 1'b0;
            bus_local_command_mode_o <= 1'b0;
            run_disable_o            <= 1'b0;
        end else begin
            external_location_b_o    <= f_extb; // R05
            panel_local_lockout_o    <= f_lock; // R13
            bus_local_command_mode_o <= cwh_busloc_ff; // R15
            run_disable_o            <= f_rundis; // R18
        end
    end

    // ----------------------------------------
    // Ramp and torque limit outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_pair2_o                 <= 1'b0;
            ramp_out_zero_o              <= 1'b0;
            ramp_hold_o                  <= 1'b0;
            ramp_in_zero_o               <= 1'b0;
            second_torque_limit_select_o <= 1'b0;
        end else begin
            ramp_pair2_o                 <= f_ramp2; // R09
            ramp_out_zero_o              <= f_rout0; // R10
            ramp_hold_o                  <= f_rhold; // R11
            ramp_in_zero_o               <= f_rin0; // R12
            second_torque_limit_select_o <= f_tlim2; // R14
        end
    end

    assign halt_mode_o  = mode_ff;
    assign cmd_state_o  = state_ff;
    assign local_mode_o = local_ff;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // State and mode in the low bits, one flag per bit above
    wire [31:0] stat_word = {19'h0,
                             f_tlim2,
                             local_ff,
                             cwh_busloc_ff,
                             f_lock,
                             reverse_o,
                             f_rundis,
                             f_extb,
                             halt_cmd_o,
                             run_cmd_o,
                             mode_ff,
                             state_ff};

    // Unmapped addresses read as zero
    wire [31:0] cwl_word  = {16'h0000, cwl_ff};
    wire [31:0] cwh_word  = {15'h0, cwh_busloc_ff, 16'h0000};
    wire [31:0] hcfg_word = {30'h0, hcfg_ff};

    wire [31:0] rd_mux = rd_cwl  ? cwl_word :
                         rd_cwh  ? cwh_word :
                         rd_hcfg ? hcfg_word :
                         rd_stat ? stat_word :
                         `CWD_RD_ZERO;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `CWD_RD_ZERO;
        end else begin
            rdata_o <= rd_i ? rd_mux : `CWD_RD_ZERO;
        end
    end

endmodule

// ### cwd_fb_master.sv
`timescale 1ns/1ns
`include "cwd_map.svh"
module cwd_fb_master (
    // Clock
    input  wire logic              clk_i,
    // Register port toward the decoder
    output logic [`CWD_AW-1:0]     addr_o,
    output logic [31:0]            wdata_o,
    output logic                   wr_o,
    output logic                   rd_o,
    input  wire logic [31:0]       rdata_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0000_0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Whole 32-bit word each access; released lines show the inverse
    task automatic wr(input logic [`CWD_AW-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [`CWD_AW-1:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask
endmodule

// ### cwd_decoder_sva.sv
`timescale 1ns/1ns
`include "cwd_map.svh"
module cwd_decoder_sva (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [`CWD_AW-1:0] addr_i,
    input wire logic [31:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [31:0]       rdata_o,
    input wire logic              ref_sign_i,
    input wire logic              panel_location_key_i,
    input wire logic              run_cmd_o,
    input wire logic              halt_cmd_o,
    input wire logic              reverse_o,
    input wire logic              local_mode_o,
    input wire logic              external_location_b_o,
    input wire logic              panel_local_lockout_o,
    input wire logic              bus_local_command_mode_o,
    input wire logic              run_disable_o,
    input wire logic              fault_reset_o,
    input wire logic              ramp_pair2_o,
    input wire logic              ramp_out_zero_o,
    input wire logic              ramp_hold_o,
    input wire logic              ramp_in_zero_o,
    input wire logic              second_torque_limit_select_o
);
    // Shadow of the low word, needed for edge and readback checks
    logic [15:0] cwl_ff;
    wire         lw   = wr_i && addr_i == `CWD_OFF_CWL;
    wire         rise = lw && wdata_i[4] && !cwl_ff[4];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) cwl_ff <= 16'h0000;
        else if (lw) cwl_ff <= wdata_i[15:0];
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence low_wr_s;
        wr_i && addr_i == `CWD_OFF_CWL;
    endsequence
    sequence key_lock_s;
        panel_location_key_i && panel_local_lockout_o && !local_mode_o;
    endsequence

    run_stop_a: assert property (low_wr_s |-> ##2 halt_cmd_o == $past(wdata_i[0], 2)
        && run_cmd_o == ($past(wdata_i[1], 2) && !$past(wdata_i[0], 2))) else $error("run stop wrong");
    dir_xor_a: assert property (reverse_o == ($past(cwl_ff[2]) ^ $past(ref_sign_i)))
        else $error("direction wrong");
    ctl_bits_a: assert property ({run_disable_o, external_location_b_o,
        second_torque_limit_select_o, panel_local_lockout_o, ramp_in_zero_o,
        ramp_hold_o, ramp_out_zero_o, ramp_pair2_o}
        == {$past(cwl_ff[6:5]), $past(cwl_ff[15:10])}) else $error("control bits wrong");
    fault_rise_a: assert property (fault_reset_o == $past(rise)) else $error("fault reset wrong");
    rd_back_a: assert property (rd_i && addr_i == `CWD_OFF_CWL |=> rdata_o[15:0] == $past(cwl_ff))
        else $error("readback wrong");
    rd_zero_a: assert property (!rd_i |=> rdata_o == `CWD_RD_ZERO) else $error("idle read data");
    bus_loc_a: assert property (wr_i && addr_i == `CWD_OFF_CWH |-> ##2
        bus_local_command_mode_o == $past(wdata_i[16], 2)) else $error("bus local wrong");
    local_wr_a: assert property (low_wr_s |-> ##2 local_mode_o == $past(wdata_i[3], 2))
        else $error("local mode wrong");
    key_lock_a: assert property (key_lock_s |=> !local_mode_o [*2]) else $error("lockout ignored");
endmodule

bind cwd_decoder cwd_decoder_sva chk_u (.*);

// ### fieldbus_control_word_decoder_tb_top.sv
`timescale 1ns/1ns
`include "cwd_map.svh"
module fieldbus_control_word_decoder_tb_top
    import cwd_pkg::*;
;
    logic clk_i, rst_i, wr_i, rd_i, ref_sign_i, panel_location_key_i, halt_done_i;
    logic [`CWD_AW-1:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic run_cmd_o, halt_cmd_o, reverse_o, local_mode_o, external_location_b_o;
    logic panel_local_lockout_o, bus_local_command_mode_o, run_disable_o, fault_reset_o;
    logic ramp_pair2_o, ramp_out_zero_o, ramp_hold_o, ramp_in_zero_o, second_torque_limit_select_o;
    cwd_halt_t halt_mode_o;
    cwd_state_t cmd_state_o;
    int fails, tests_run, i;
    logic [15:0] mw[5] = '{16'h0003, 16'h0101, 16'h0201, 16'h0481, 16'h0001};
    logic [31:0] mc[5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
    cwd_halt_t me[5] = '{cwd_hm_ramp, cwd_hm_emer, cwd_hm_coast, cwd_hm_ramp, cwd_hm_coast};
    logic [15:0] bw[3] = '{16'hfc68, 16'h5420, 16'ha848};

    cwd_decoder dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ref_sign_i(ref_sign_i), .panel_location_key_i(panel_location_key_i),
        .halt_done_i(halt_done_i), .run_cmd_o(run_cmd_o), .halt_cmd_o(halt_cmd_o), .halt_mode_o(halt_mode_o),
        .cmd_state_o(cmd_state_o), .reverse_o(reverse_o), .local_mode_o(local_mode_o),
        .external_location_b_o(external_location_b_o), .panel_local_lockout_o(panel_local_lockout_o),
        .bus_local_command_mode_o(bus_local_command_mode_o), .run_disable_o(run_disable_o),
        .fault_reset_o(fault_reset_o), .ramp_pair2_o(ramp_pair2_o), .ramp_out_zero_o(ramp_out_zero_o),
        .ramp_hold_o(ramp_hold_o), .ramp_in_zero_o(ramp_in_zero_o),
        .second_torque_limit_select_o(second_torque_limit_select_o));
    cwd_fb_master m_u (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
                       .rd_o(rd_i), .rdata_i(rdata_o));

    always #5 clk_i = ~clk_i;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // Bounded wait on the sequencer; a hang ends the run
    task automatic wst(input cwd_state_t s);
        int k;
        for (k = 0; k < 20 && cmd_state_o !== s; k++) begin
            @(posedge clk_i);
            #1;
        end
        if (cmd_state_o !== s) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic pk();
        @(posedge clk_i);
        panel_location_key_i <= 1'b1;
        @(posedge clk_i);
        panel_location_key_i <= 1'b0;
        settle();
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ref_sign_i = 1'b0;
        panel_location_key_i = 1'b0;
        halt_done_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        m_u.rd(`CWD_OFF_CWL, d);
        chk("low word reset", `CWD_RD_ZERO, d);
        m_u.wr(`CWD_OFF_HCFG, 32'h0000_0003);
        m_u.rd(`CWD_OFF_HCFG, d);
        chk("stop mode code", `CWD_RD_ZERO, d);
        m_u.rd(8'h10, d);
        chk("unmapped read", `CWD_RD_ZERO, d);
        for (i = 0; i < 5; i++) begin
            m_u.wr(`CWD_OFF_HCFG, mc[i]);
            halt_done_i <= 1'b0;
            m_u.wr(`CWD_OFF_CWL, 32'h0000_0002);
            wst(cwd_st_run);
            chk("run", 32'h1, run_cmd_o);
            m_u.wr(`CWD_OFF_CWL, {16'h0000, mw[i]});
            wst(cwd_st_halt);
            settle();
            chk("run off", 32'h0, run_cmd_o);
            chk("halt", 32'h1, halt_cmd_o);
            chk("halt mode", me[i], halt_mode_o);
            chk("ramp pair", {31'h0, mw[i][10]}, ramp_pair2_o);
            @(posedge clk_i);
            halt_done_i <= 1'b1;
            wst(cwd_st_idle);
        end
        for (i = 0; i < 3; i++) begin
            m_u.wr(`CWD_OFF_CWL, {16'h0000, bw[i]});
            settle();
            chk("bits", {bw[i][3], bw[i][5], bw[i][6], bw[i][15:10]},
                {local_mode_o, external_location_b_o, run_disable_o, second_torque_limit_select_o,
                panel_local_lockout_o, ramp_in_zero_o, ramp_hold_o, ramp_out_zero_o, ramp_pair2_o});
            m_u.rd(`CWD_OFF_CWL, d);
            chk("readback", {16'h0000, bw[i]}, d);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            ref_sign_i <= i[0];
            m_u.wr(`CWD_OFF_CWL, {29'h0, i[1], 2'b00});
            settle();
            chk("reverse", i[1] ^ i[0], reverse_o);
        end
        m_u.wr(`CWD_OFF_CWL, 32'h0000_0010);
        #1 chk("fault pulse", 32'h1, fault_reset_o);
        @(posedge clk_i);
        #1 chk("fault end", 32'h0, fault_reset_o);
        m_u.wr(`CWD_OFF_CWL, 32'h0000_0010);
        #1 chk("fault steady", 32'h0, fault_reset_o);
        m_u.wr(`CWD_OFF_CWL, 32'h0000_0000);
        pk();
        chk("key to local", 32'h1, local_mode_o);
        pk();
        chk("key to remote", 32'h0, local_mode_o);
        m_u.wr(`CWD_OFF_CWL, 32'h0000_4000);
        settle();
        pk();
        chk("key locked", 32'h0, local_mode_o);
        m_u.wr(`CWD_OFF_CWH, 32'h0001_0000);
        settle();
        chk("bus local", 32'h1, bus_local_command_mode_o);
        m_u.rd(`CWD_OFF_STAT, d);
        chk("status word", 32'h0000_0704, d);
        m_u.wr(`CWD_OFF_CWH, 32'h0000_0000);
        settle();
        chk("bus local off", 32'h0, bus_local_command_mode_o);
        give_verdict();
    end
endmodule
